// *** fpbv_pkg.sv ***
// Shared constants and carriers for the frame pointer and byte view block
package fpbv_pkg;

	// Widths
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int OFFS_W   = 8;
	localparam int LANES    = 2;
	localparam int SIGN_BIT = 7;
	localparam int WBS_BIT  = 4;

	// Register locations
	localparam logic [ADDR_W-1:0] ADDR_OFFSET  = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_GENERAL = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_LOWER   = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_BASE    = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_SWAP    = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_UPPER   = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_SEXT    = 4'hA;
	localparam logic [ADDR_W-1:0] ADDR_SUM     = 4'hB;

	// Reset values
	localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
	localparam logic [OFFS_W-1:0] RST_OFFS = 8'h00;
	localparam logic              RST_CTRL = 1'h0;

	// Lane write enables
	localparam logic [LANES-1:0] LANE_NONE = 2'h0;
	localparam logic [LANES-1:0] LANE_LOW  = 2'h1;
	localparam logic [LANES-1:0] LANE_HIGH = 2'h2;
	localparam logic [LANES-1:0] LANE_BOTH = 2'h3;

	// Register port request from the core
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fpbv_bus_req_type;

	// Third data pointer handed to the memory path
	typedef struct packed {
		logic [DATA_W-1:0] addr;
		logic              word_mode;
	} fpbv_ptr_type;

endpackage : fpbv_pkg

// *** fpbv_lane_reg.sv ***
`timescale 1ns/1ps
// Word register written per byte lane, cleared by reset
module fpbv_lane_reg #(
	parameter int                       LANES  = 2,
	parameter int                       LANE_W = 8,
	parameter logic [LANES*LANE_W-1:0]  RST    = '0
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Lane write
	input  wire logic [LANES-1:0]        lane_we,
	input  wire logic [LANES*LANE_W-1:0] lane_data,
	// Stored word
	output logic      [LANES*LANE_W-1:0] q
);

	// One flop group per lane so a byte write leaves the other lane alone
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				q[i*LANE_W +: LANE_W] <= RST[i*LANE_W +: LANE_W];
			end else if (lane_we[i]) begin
				q[i*LANE_W +: LANE_W] <= lane_data[i*LANE_W +: LANE_W];
			end
		end
	end

endmodule : fpbv_lane_reg

// *** fpbv_top.sv ***
`timescale 1ns/1ps
// Operation
// - Frame base is a 16-bit read/write register, zero after reset.
// - Frame pointer is base plus offset, unsigned, used as third data pointer.
// - Carry out of an offset step never changes the frame base.
// - Frame pointer sum location is read only, reads zero after reset.
// - Swapped view returns the general word with bytes exchanged, read only.
// - Upper byte location writes and reads only the general word high byte.
// - Upper byte view reads zero right after reset.
// - Sign-extended view returns low byte with bit 7 copied upward.
// - Sign-extended view reads zero after reset and ignores writes.
// - General word is a 16-bit read/write register, zero after reset.
// - Lower byte location writes and reads only the general word low byte.
// - Control bit picks word access when set, byte access when clear.
module fpbv_top (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// Register port
	input  wire fpbv_pkg::fpbv_bus_req_type bus_req,
	output logic [fpbv_pkg::DATA_W-1:0]    rd_data_ff,
	// Offset stepping from the core
	input  wire logic                      offs_inc,
	input  wire logic                      offs_dec,
	// Third data pointer
	output fpbv_pkg::fpbv_ptr_type         frame_ptr_ff
);

	logic [fpbv_pkg::DATA_W-1:0] frame_base;
	logic [fpbv_pkg::DATA_W-1:0] general_word;
	logic [fpbv_pkg::OFFS_W-1:0] offset_ff;
	logic [fpbv_pkg::OFFS_W-1:0] nxt_offset;
	logic                        frame_word_byte_select_ff;
	logic [fpbv_pkg::DATA_W-1:0] frame_pointer_sum;
	logic [fpbv_pkg::DATA_W-1:0] nxt_rd_data;
	logic [fpbv_pkg::LANES-1:0]  base_we;
	logic [fpbv_pkg::LANES-1:0]  gen_we;
	logic [fpbv_pkg::DATA_W-1:0] gen_data;
	logic [fpbv_pkg::BYTE_W-1:0] general_lower_byte;
	logic [fpbv_pkg::BYTE_W-1:0] general_upper_byte;
	logic [fpbv_pkg::DATA_W-1:0] general_swapped_view;
	logic [fpbv_pkg::DATA_W-1:0] general_sign_extended_low;
	logic                        wr_hit;

	assign wr_hit = bus_req.wr;

	// Byte views of the general word
	assign general_lower_byte        = general_word[fpbv_pkg::BYTE_W-1:0];
	assign general_upper_byte        = general_word[fpbv_pkg::DATA_W-1:fpbv_pkg::BYTE_W];
	assign general_swapped_view      = {general_lower_byte, general_upper_byte};
	assign general_sign_extended_low = {{fpbv_pkg::BYTE_W{general_word[fpbv_pkg::SIGN_BIT]}},
		general_lower_byte};

	// Unsigned sum, carry beyond bit 15 dropped
	assign frame_pointer_sum = 16'(frame_base + 16'(offset_ff));

	// Frame base takes only whole-word writes at its own location
	assign base_we = (wr_hit && bus_req.addr == fpbv_pkg::ADDR_BASE) ?
		fpbv_pkg::LANE_BOTH : fpbv_pkg::LANE_NONE;

	fpbv_lane_reg #(
		.LANES  (fpbv_pkg::LANES),
		.LANE_W (fpbv_pkg::BYTE_W),
		.RST    (fpbv_pkg::RST_WORD)
	) u_frame_base (
		.clk       (clk),
		.nrst      (nrst),
		.lane_we   (base_we),
		.lane_data (bus_req.wdata),
		.q         (frame_base)
	);

	// General word lane steering; byte locations carry their byte in the low bits
	always_comb begin
		gen_we   = fpbv_pkg::LANE_NONE;
		gen_data = bus_req.wdata;
		if (wr_hit) begin
			unique case (bus_req.addr)
				fpbv_pkg::ADDR_GENERAL: begin
					gen_we = fpbv_pkg::LANE_BOTH;
				end
				fpbv_pkg::ADDR_LOWER: begin
					gen_we = fpbv_pkg::LANE_LOW;
				end
				fpbv_pkg::ADDR_UPPER: begin
					gen_we   = fpbv_pkg::LANE_HIGH;
					gen_data = {bus_req.wdata[fpbv_pkg::BYTE_W-1:0], bus_req.wdata[fpbv_pkg::BYTE_W-1:0]};
				end
				default: begin
					// Swap, sign-extended and sum views are read only
					gen_we = fpbv_pkg::LANE_NONE;
				end
			endcase
		end
	end

	fpbv_lane_reg #(
		.LANES  (fpbv_pkg::LANES),
		.LANE_W (fpbv_pkg::BYTE_W),
		.RST    (fpbv_pkg::RST_WORD)
	) u_general_word (
		.clk       (clk),
		.nrst      (nrst),
		.lane_we   (gen_we),
		.lane_data (gen_data),
		.q         (general_word)
	);

	// Offset: a write wins over a step; step carry is simply lost
	always_comb begin
		nxt_offset = offset_ff;
		if (wr_hit && bus_req.addr == fpbv_pkg::ADDR_OFFSET) begin
			nxt_offset = bus_req.wdata[fpbv_pkg::OFFS_W-1:0];
		end else if (offs_inc && !offs_dec) begin
			nxt_offset = offset_ff + 8'h01;
		end else if (offs_dec && !offs_inc) begin
			nxt_offset = offset_ff - 8'h01;
		end
	end

	// Offset register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			offset_ff <= fpbv_pkg::RST_OFFS;
		end else begin
			offset_ff <= nxt_offset;
		end
	end

	// Word or byte access through the frame pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_word_byte_select_ff <= fpbv_pkg::RST_CTRL;
		end else if (wr_hit && bus_req.addr == fpbv_pkg::ADDR_CONTROL) begin
			frame_word_byte_select_ff <= bus_req.wdata[fpbv_pkg::WBS_BIT];
		end
	end

	// Pointer to the memory path, one cycle behind the registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_ptr_ff.addr      <= fpbv_pkg::RST_WORD;
			frame_ptr_ff.word_mode <= fpbv_pkg::RST_CTRL;
		end else begin
			frame_ptr_ff.addr      <= frame_pointer_sum;
			frame_ptr_ff.word_mode <= frame_word_byte_select_ff;
		end
	end

	// Read multiplexer; unmapped locations and reserved bits read zero
	always_comb begin
		nxt_rd_data = fpbv_pkg::RST_WORD;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				fpbv_pkg::ADDR_OFFSET: begin
					nxt_rd_data = 16'(offset_ff);
				end
				fpbv_pkg::ADDR_CONTROL: begin
					nxt_rd_data[fpbv_pkg::WBS_BIT] = frame_word_byte_select_ff;
				end
				fpbv_pkg::ADDR_GENERAL: begin
					nxt_rd_data = general_word;
				end
				fpbv_pkg::ADDR_LOWER: begin
					nxt_rd_data = 16'(general_lower_byte);
				end
				fpbv_pkg::ADDR_BASE: begin
					nxt_rd_data = frame_base;
				end
				fpbv_pkg::ADDR_SWAP: begin
					nxt_rd_data = general_swapped_view;
				end
				fpbv_pkg::ADDR_UPPER: begin
					nxt_rd_data = 16'(general_upper_byte);
				end
				fpbv_pkg::ADDR_SEXT: begin
					nxt_rd_data = general_sign_extended_low;
				end
				fpbv_pkg::ADDR_SUM: begin
					nxt_rd_data = frame_pointer_sum;
				end
				default: begin
					nxt_rd_data = fpbv_pkg::RST_WORD;
				end
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_ff <= fpbv_pkg::RST_WORD;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	localparam logic [fpbv_pkg::OFFS_W-1:0] OFFS_TOP = 8'hFF;

	a_base_write: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_BASE)
		|=> bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_BASE ##1 rd_data_ff == $past(bus_req.wdata, 2)
		or !(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_BASE))
		else $error("frame base write not read back");

	a_sum_track: assert property (
		1'b1 |=> frame_ptr_ff.addr == 16'($past(frame_base) + 16'($past(offset_ff))))
		else $error("frame pointer is not base plus offset");

	a_carry_base: assert property (
		(offs_inc && !offs_dec && offset_ff == OFFS_TOP && !base_we[0]
		&& !(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_OFFSET))
		|=> offset_ff == fpbv_pkg::RST_OFFS && $stable(frame_base))
		else $error("offset carry disturbed frame base");

	a_sum_readonly: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_SUM && !offs_inc && !offs_dec)
		|=> $stable(frame_base) && $stable(general_word) && $stable(offset_ff))
		else $error("write to sum location changed state");

	a_swap_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_SWAP)
		|=> rd_data_ff == {$past(general_word[7:0]), $past(general_word[15:8])})
		else $error("swapped view wrong");

	a_upper_write: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_UPPER)
		|=> general_word == {$past(bus_req.wdata[7:0]), $past(general_word[7:0])})
		else $error("upper byte write wrong");

	a_upper_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_UPPER)
		|=> rd_data_ff == {8'h00, $past(general_word[15:8])})
		else $error("upper byte read wrong");

	a_sext_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_SEXT)
		|=> rd_data_ff == {{8{$past(general_word[7])}}, $past(general_word[7:0])})
		else $error("sign-extended view wrong");

	a_sext_nowrite: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_SEXT) |=> $stable(general_word))
		else $error("sign-extended view accepted a write");

	a_word_write: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_GENERAL)
		|=> general_word == $past(bus_req.wdata))
		else $error("general word write lost");

	a_lower_write: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_LOWER)
		|=> general_word == {$past(general_word[15:8]), $past(bus_req.wdata[7:0])})
		else $error("lower byte write wrong");

	a_mode_follow: assert property (
		(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_CONTROL)
		|=> ##1 frame_ptr_ff.word_mode == $past(bus_req.wdata[fpbv_pkg::WBS_BIT], 2))
		else $error("word mode did not follow control write");

	a_sum_wrap: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_SUM)
		|=> rd_data_ff == 16'($past(frame_base) + {8'h00, $past(offset_ff)}))
		else $error("sum read does not wrap");

	// Stored locations read back exactly what they hold; an offset borrow leaves the frame base alone
	a_base_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_BASE)
		|=> rd_data_ff == $past(frame_base))
		else $error("frame base read wrong");

	a_borrow_base: assert property (
		(offs_dec && !offs_inc && offset_ff == fpbv_pkg::RST_OFFS && !base_we[0]
		&& !(bus_req.wr && bus_req.addr == fpbv_pkg::ADDR_OFFSET))
		|=> offset_ff == OFFS_TOP && $stable(frame_base))
		else $error("offset borrow disturbed frame base");

	a_word_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_GENERAL)
		|=> rd_data_ff == $past(general_word))
		else $error("general word read wrong");

	a_lower_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_LOWER)
		|=> rd_data_ff == {8'h00, $past(general_word[7:0])})
		else $error("lower byte read wrong");

	a_ctrl_read: assert property (
		(bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_CONTROL)
		|=> rd_data_ff == (16'($past(frame_word_byte_select_ff)) << fpbv_pkg::WBS_BIT))
		else $error("control read wrong");

	// Scenarios every run should reach
	c_carry:   cover property (offs_inc && offset_ff == OFFS_TOP);
	c_borrow:  cover property (offs_dec && !offs_inc && offset_ff == fpbv_pkg::RST_OFFS);
	c_wrap:    cover property (bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_SUM
		&& {1'b0, frame_base} + 17'(offset_ff) > 17'h0FFFF);
	c_neg_ext: cover property (bus_req.rd && bus_req.addr == fpbv_pkg::ADDR_SEXT && general_word[7]);
	c_b2b:     cover property (bus_req.wr ##1 bus_req.rd);

endmodule : fpbv_top

// *** test_fpbv_top.sv ***
`timescale 1ns/1ps
module test_fpbv_top;

	// Clock, reset and design ports
	logic                         clk;
	logic                         nrst;
	fpbv_pkg::fpbv_bus_req_type   req;
	logic [fpbv_pkg::DATA_W-1:0]  rd_data;
	logic                         offs_inc;
	logic                         offs_dec;
	fpbv_pkg::fpbv_ptr_type       fptr;

	// Bench bookkeeping and reference model
	int                           error_cnt;
	int                           total_checks;
	int                           cyc_cnt;
	logic [15:0]                  seed;
	logic [7:0]                   m_offs;
	logic                         m_ctrl;
	logic [15:0]                  m_gw;
	logic [15:0]                  m_base;

	fpbv_top DUT (
		.clk          (clk),
		.nrst         (nrst),
		.bus_req      (req),
		.rd_data_ff   (rd_data),
		.offs_inc     (offs_inc),
		.offs_dec     (offs_dec),
		.frame_ptr_ff (fptr)
	);

	// Free-running 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Hang guard, generous for the random loop
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// Fixed-seed shift register for stimulus
	function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt_lfsr

	// Expected read value from the model
	function automatic logic [15:0] exp_rd(input logic [3:0] a);
		case (a)
			fpbv_pkg::ADDR_OFFSET:  return {8'h00, m_offs};
			fpbv_pkg::ADDR_CONTROL: return {11'h000, m_ctrl, 4'h0};
			fpbv_pkg::ADDR_GENERAL: return m_gw;
			fpbv_pkg::ADDR_LOWER:   return {8'h00, m_gw[7:0]};
			fpbv_pkg::ADDR_BASE:    return m_base;
			fpbv_pkg::ADDR_SWAP:    return {m_gw[7:0], m_gw[15:8]};
			fpbv_pkg::ADDR_UPPER:   return {8'h00, m_gw[15:8]};
			fpbv_pkg::ADDR_SEXT:    return {{8{m_gw[7]}}, m_gw[7:0]};
			fpbv_pkg::ADDR_SUM:     return m_base + {8'h00, m_offs};
			default:                return 16'h0000;
		endcase
	endfunction : exp_rd

	task automatic model_clear();
		m_offs = 8'h00;
		m_ctrl = 1'h0;
		m_gw   = 16'h0000;
		m_base = 16'h0000;
	endtask : model_clear

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Model side of a write; read-only and unmapped places leave it alone
	task automatic model_wr(input logic [3:0] a, input logic [15:0] d);
		case (a)
			fpbv_pkg::ADDR_OFFSET:  m_offs = d[7:0];
			fpbv_pkg::ADDR_CONTROL: m_ctrl = d[fpbv_pkg::WBS_BIT];
			fpbv_pkg::ADDR_GENERAL: m_gw = d;
			fpbv_pkg::ADDR_LOWER:   m_gw[7:0] = d[7:0];
			fpbv_pkg::ADDR_BASE:    m_base = d;
			fpbv_pkg::ADDR_UPPER:   m_gw[15:8] = d[7:0];
			default:                ;
		endcase
	endtask : model_wr

	// One-cycle write
	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req.wr    <= 1'h1;
		req.addr  <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr    <= 1'h0;
		model_wr(a, d);
	endtask : bus_wr

	// Write then read of one place with no idle cycle between the strobes
	task automatic bus_wr_rd(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req.wr    <= 1'h1;
		req.addr  <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr    <= 1'h0;
		req.rd    <= 1'h1;
		model_wr(a, d);
		@(posedge clk);
		req.rd    <= 1'h0;
		@(negedge clk);
		chk(rd_data, exp_rd(a));
	endtask : bus_wr_rd

	// Read, then confirm the data stand for one cycle only
	task automatic bus_rd(input logic [3:0] a);
		@(posedge clk);
		req.rd   <= 1'h1;
		req.addr <= a;
		@(posedge clk);
		req.rd   <= 1'h0;
		@(negedge clk);
		chk(rd_data, exp_rd(a));
		@(negedge clk);
		chk(rd_data, 16'h0000);
	endtask : bus_rd

	task automatic rd_all();
		for (int a = 0; a < 16; a++) bus_rd(a[3:0]);
	endtask : rd_all

	// Offset step of one cycle; both high means no step
	task automatic step(input logic i, input logic d);
		@(posedge clk);
		offs_inc <= i;
		offs_dec <= d;
		@(posedge clk);
		offs_inc <= 1'h0;
		offs_dec <= 1'h0;
		if (i && !d) m_offs = m_offs + 8'h01;
		if (d && !i) m_offs = m_offs - 8'h01;
	endtask : step

	// Pointer output lags the registers by one cycle
	task automatic chk_ptr();
		@(posedge clk);
		@(negedge clk);
		chk(fptr.addr, m_base + {8'h00, m_offs});
		chk({15'h0000, fptr.word_mode}, {15'h0000, m_ctrl});
	endtask : chk_ptr

	// Main sequence
	initial begin
		nrst         = 1'h0;
		req          = '0;
		offs_inc     = 1'h0;
		offs_dec     = 1'h0;
		error_cnt    = 0;
		total_checks = 0;
		cyc_cnt      = 0;
		seed         = 16'h0037;
		model_clear();
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		rd_all();
		chk_ptr();
		// Offset carry and borrow must not touch the base
		bus_wr(fpbv_pkg::ADDR_BASE, 16'hFFFF);
		bus_wr(fpbv_pkg::ADDR_OFFSET, 16'h00FF);
		step(1'h1, 1'h0);
		chk_ptr();
		bus_rd(fpbv_pkg::ADDR_BASE);
		step(1'h0, 1'h1);
		step(1'h1, 1'h1);
		bus_rd(fpbv_pkg::ADDR_OFFSET);
		bus_rd(fpbv_pkg::ADDR_SUM);
		bus_wr(fpbv_pkg::ADDR_BASE, 16'hFFF0);
		bus_wr(fpbv_pkg::ADDR_OFFSET, 16'h0020);
		bus_rd(fpbv_pkg::ADDR_SUM);
		chk_ptr();
		// Byte views, negative low byte, and writes to read-only places
		bus_wr(fpbv_pkg::ADDR_GENERAL, 16'h1280);
		bus_wr(fpbv_pkg::ADDR_UPPER, 16'h55AB);
		bus_wr(fpbv_pkg::ADDR_LOWER, 16'hAAF3);
		bus_wr(fpbv_pkg::ADDR_SWAP, 16'h1234);
		bus_wr(fpbv_pkg::ADDR_SEXT, 16'h5678);
		bus_wr(fpbv_pkg::ADDR_SUM, 16'h9ABC);
		bus_wr(4'hF, 16'hDEAD);
		bus_wr(fpbv_pkg::ADDR_CONTROL, 16'hFFFF);
		rd_all();
		chk_ptr();
		bus_wr_rd(fpbv_pkg::ADDR_UPPER, 16'h0042);
		bus_wr_rd(fpbv_pkg::ADDR_BASE, 16'h8001);
		bus_wr_rd(fpbv_pkg::ADDR_LOWER, 16'h00C5);
		// Random mix of accesses and steps
		for (int n = 0; n < 400; n++) begin
			seed = nxt_lfsr(seed);
			case (seed[1:0])
				2'h0: bus_wr(seed[7:4], nxt_lfsr(seed ^ 16'hA5C3));
				2'h1: bus_rd(seed[7:4]);
				2'h2: step(seed[2], seed[3]);
				default: chk_ptr();
			endcase
		end
		// Second reset in mid-run clears everything; load non-zero state first
		bus_wr(fpbv_pkg::ADDR_GENERAL, 16'hBEEF);
		bus_wr(fpbv_pkg::ADDR_BASE, 16'h1357);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(rd_data, 16'h0000);
		chk(fptr.addr, 16'h0000);
		@(posedge clk);
		nrst <= 1'h1;
		model_clear();
		rd_all();
		chk_ptr();
		wrap_up();
	end

endmodule : test_fpbv_top
